/* File: hw/tap_pkg.sv */
// shared constants for the memory test access port
package tap_pkg;
  localparam int          IR_W          = 3;
  localparam int          BYPASS_W      = 1;
  localparam int          ID_W          = 32;
  localparam int          BSR_W_X36     = 73;
  localparam int          BSR_W_X18     = 54;
  localparam logic [2:0]  INS_EXTEST    = 3'h0;
  localparam logic [2:0]  INS_SAMPLE_Z  = 3'h1;
  localparam logic [2:0]  INS_IDCODE    = 3'h2;
  localparam logic [2:0]  INS_SAMPLE    = 3'h3;
  localparam logic [2:0]  INS_BYPASS    = 3'h7;
  localparam logic [1:0]  IR_CAPTURE    = 2'h1;
  localparam logic [31:0] ID_VALUE      = 32'h1234_5679;
  localparam int          RESET_TMS_CNT = 5;
  typedef enum logic [3:0] {
    S_RESET, S_IDLE, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PAU_DR, S_EX2_DR, S_UPD_DR,
    S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PAU_IR, S_EX2_IR, S_UPD_IR
  } tap_state_t;
endpackage

/* File: hw/pin_sync.sv */
// three-stage synchroniser that reports a level once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic core_clk_in,
  input  wire logic resetn_in,
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      s1_q      <= RESET_VAL;
      s2_q      <= RESET_VAL;
      s3_q      <= RESET_VAL;
      level_out <= RESET_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_out <= s3_q;
      end
    end
  end
endmodule

/* File: hw/mem_tap.sv */
// test access port of the synchronous memory, sampled on the core clock
//
// Operation
// - sample on test clock rise, drive on fall
// - state machine steps by mode select each rise
// - floating mode select reads as high
// - instruction picks one register in scan path
// - serial input enters register most significant bit
// - serial output shows lsb, shifting states only
// - five high mode select edges force reset
// - port reset leaves memory function alone
// - power-up reset leaves serial output floating
// - three-bit instruction shifts in during Shift-IR
// - reset loads identification-read instruction
// - Capture-IR loads 01 into low bits
// - one-bit bypass stage between input and output
// - bypass instruction clears bypass bit
// - boundary register one bit per pin
// - Capture-DR snapshots pins, Shift-DR shifts them
// - extest, sample, sample-z capture the pin ring
// - identification register captures fixed 32-bit code
// - all-zero instruction samples and floats outputs
// - sample-z shifts boundary and floats outputs
// - Update-DR under sample acts like pause
`timescale 1ns/1ps
module mem_tap #(
  parameter int BSR_W = tap_pkg::BSR_W_X36
) (
  input  wire logic             core_clk_in,
  input  wire logic             resetn_in,
  input  wire logic             tck_in,
  input  wire logic             tms_in,
  input  wire logic             tms_driven_in,
  input  wire logic             tdi_in,
  input  wire logic [BSR_W-1:0] pins_in,
  output logic                  tdo_out,
  output logic                  tdo_oe_out,
  output logic                  mem_hiz_out,
  output logic [2:0]            ir_out
);
  import tap_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tms_raw;
  logic tck_q;

  // an undriven mode select pulls high, keeping the port parked in reset
  assign tms_raw = tms_driven_in ? tms_in : 1'b1;

  pin_sync #(.RESET_VAL(1'b0)) u_tck (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .pin_in      (tck_in),
    .level_out   (tck_s)
  );
  pin_sync #(.RESET_VAL(1'b1)) u_tms (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .pin_in      (tms_raw),
    .level_out   (tms_s)
  );
  pin_sync #(.RESET_VAL(1'b1)) u_tdi (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .pin_in      (tdi_in),
    .level_out   (tdi_s)
  );

  // ----------------------------------------------------------------
  // test clock edges
  // ----------------------------------------------------------------
  logic rise;
  logic fall;

  // a held-low test clock yields no edges, so the port never moves
  assign rise = tck_s & ~tck_q;
  assign fall = ~tck_s & tck_q;

  // ----------------------------------------------------------------
  // controller state machine
  // ----------------------------------------------------------------
  tap_state_t state_q;
  tap_state_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_RESET:  state_d = tms_s ? S_RESET  : S_IDLE;
      S_IDLE:   state_d = tms_s ? S_SEL_DR : S_IDLE;
      S_SEL_DR: state_d = tms_s ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: state_d = tms_s ? S_EX1_DR : S_SH_DR;
      S_SH_DR:  state_d = tms_s ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: state_d = tms_s ? S_UPD_DR : S_PAU_DR;
      S_PAU_DR: state_d = tms_s ? S_EX2_DR : S_PAU_DR;
      S_EX2_DR: state_d = tms_s ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: state_d = tms_s ? S_SEL_DR : S_IDLE;
      S_SEL_IR: state_d = tms_s ? S_RESET  : S_CAP_IR;
      S_CAP_IR: state_d = tms_s ? S_EX1_IR : S_SH_IR;
      S_SH_IR:  state_d = tms_s ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: state_d = tms_s ? S_UPD_IR : S_PAU_IR;
      S_PAU_IR: state_d = tms_s ? S_EX2_IR : S_PAU_IR;
      S_EX2_IR: state_d = tms_s ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: state_d = tms_s ? S_SEL_DR : S_IDLE;
      default:  state_d = S_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  logic [IR_W-1:0] ir_q;
  logic [IR_W-1:0] ir_sh_q;
  logic            sel_bsr;
  logic            sel_id;
  logic            sel_byp;
  logic            float_ins;

  assign sel_bsr   = (ir_q == INS_EXTEST) | (ir_q == INS_SAMPLE) | (ir_q == INS_SAMPLE_Z);
  assign sel_id    = (ir_q == INS_IDCODE);
  assign sel_byp   = ~sel_bsr & ~sel_id;
  assign float_ins = (ir_q == INS_EXTEST) | (ir_q == INS_SAMPLE_Z);

  // ----------------------------------------------------------------
  // data registers and instruction register
  // ----------------------------------------------------------------
  logic [BSR_W-1:0] bsr_q;
  logic [ID_W-1:0]  id_q;
  logic             byp_q;

  // memory port is never touched here, so port resets are harmless to it
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      tck_q   <= 1'b0;
      state_q <= S_RESET;
      ir_q    <= INS_IDCODE;
      ir_sh_q <= INS_IDCODE;
      bsr_q   <= '0;
      id_q    <= '0;
      byp_q   <= 1'b0;
    end else begin
      tck_q <= tck_s;
      if (rise) begin
        state_q <= state_d;
        case (state_q)
          S_RESET: begin
            ir_q <= INS_IDCODE;
          end
          S_CAP_IR: begin
            ir_sh_q <= {ir_q[IR_W-1:2], IR_CAPTURE};
          end
          S_SH_IR: begin
            ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
          end
          S_UPD_IR: begin
            ir_q <= ir_sh_q;
          end
          S_CAP_DR: begin
            if (sel_bsr) begin
              bsr_q <= pins_in;
            end
            if (sel_id) begin
              id_q <= ID_VALUE;
            end
            if (sel_byp) begin
              byp_q <= 1'b0;
            end
          end
          S_SH_DR: begin
            if (sel_bsr) begin
              bsr_q <= {tdi_s, bsr_q[BSR_W-1:1]};
            end
            if (sel_id) begin
              id_q <= {tdi_s, id_q[ID_W-1:1]};
            end
            if (sel_byp) begin
              byp_q <= tdi_s;
            end
          end
          // update of the data path has no target: no preload stage exists
          S_UPD_DR: begin
            bsr_q <= bsr_q;
          end
          default: begin
            byp_q <= byp_q;
          end
        endcase
        if (state_d == S_RESET) begin
          ir_q <= INS_IDCODE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // serial output, changed on the falling test clock edge; float and instruction outputs follow every core clock
  // ----------------------------------------------------------------
  logic tdo_d;
  logic shift_st;

  assign shift_st = (state_q == S_SH_IR) | (state_q == S_SH_DR);
  assign tdo_d    = (state_q == S_SH_IR) ? ir_sh_q[0] :
                    sel_bsr ? bsr_q[0] :
                    sel_id  ? id_q[0]  : byp_q;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      tdo_out     <= 1'b0;
      tdo_oe_out  <= 1'b0;
      mem_hiz_out <= 1'b0;
      ir_out      <= INS_IDCODE;
    end else begin
      mem_hiz_out <= float_ins;
      ir_out      <= ir_q;
      if (fall) begin
        tdo_out    <= tdo_d;
        tdo_oe_out <= shift_st;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [2:0] ones_cnt_q;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ones_cnt_q <= 3'h0;
    end else if (rise) begin
      ones_cnt_q <= !tms_s ? 3'h0 : (ones_cnt_q == 3'h7 ? 3'h7 : ones_cnt_q + 3'h1);
    end
  end

  property p_five_ones;
    @(posedge core_clk_in) disable iff (!resetn_in) (ones_cnt_q >= 3'(RESET_TMS_CNT)) |-> state_q == S_RESET;
  endproperty
  a_five_ones: assert property (p_five_ones) else $error("five tms highs did not reach reset");

  property p_oe_shift;
    @(posedge core_clk_in) disable iff (!resetn_in) $rose(tdo_oe_out) |-> $past(fall) && $past(shift_st);
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("tdo enabled outside shift");

  property p_tdo_on_fall;
    @(posedge core_clk_in) disable iff (!resetn_in) $changed(tdo_out) |-> $past(fall);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo moved off a falling edge");

  property p_state_on_rise;
    @(posedge core_clk_in) disable iff (!resetn_in) $changed(state_q) |-> $past(rise);
  endproperty
  a_state_on_rise: assert property (p_state_on_rise) else $error("state moved off a rising edge");

  property p_reset_ir;
    @(posedge core_clk_in) disable iff (!resetn_in) state_q == S_RESET |-> ir_q == INS_IDCODE;
  endproperty
  a_reset_ir: assert property (p_reset_ir) else $error("reset state without id instruction");

  sequence s_cap_ir;
    rise && state_q == S_CAP_IR;
  endsequence
  property p_cap_ir;
    @(posedge core_clk_in) disable iff (!resetn_in) s_cap_ir |=> ir_sh_q[1:0] == IR_CAPTURE;
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("capture-ir pattern wrong");

  property p_bypass_clear;
    @(posedge core_clk_in) disable iff (!resetn_in) rise && state_q == S_CAP_DR && sel_byp |=> !byp_q;
  endproperty
  a_bypass_clear: assert property (p_bypass_clear) else $error("bypass not cleared");

  property p_id_cap;
    @(posedge core_clk_in) disable iff (!resetn_in) rise && state_q == S_CAP_DR && sel_id |=> id_q == ID_VALUE;
  endproperty
  a_id_cap: assert property (p_id_cap) else $error("id code not captured");

  property p_hiz;
    @(posedge core_clk_in) disable iff (!resetn_in) float_ins |=> mem_hiz_out;
  endproperty
  a_hiz: assert property (p_hiz) else $error("floating instruction left outputs driven");

  property p_bsr_shift;
    @(posedge core_clk_in) disable iff (!resetn_in)
      rise && state_q == S_SH_DR && sel_bsr |=> bsr_q[BSR_W-1] == $past(tdi_s);
  endproperty
  a_bsr_shift: assert property (p_bsr_shift) else $error("tdi not entering boundary msb");

  // shift-state steps shared by the serial path checks below
  sequence s_sh_ir_rise;
    rise && state_q == S_SH_IR;
  endsequence
  sequence s_sh_dr_fall;
    fall && state_q == S_SH_DR;
  endsequence

  property p_ir_shift;
    @(posedge core_clk_in) disable iff (!resetn_in) s_sh_ir_rise |=> ir_sh_q[IR_W-1] == $past(tdi_s);
  endproperty
  a_ir_shift: assert property (p_ir_shift) else $error("tdi not entering instruction msb");

  property p_ir_load;
    @(posedge core_clk_in) disable iff (!resetn_in) rise && state_q == S_UPD_IR |=> ir_q == $past(ir_sh_q);
  endproperty
  a_ir_load: assert property (p_ir_load) else $error("update-ir did not load the instruction");

  property p_tdo_ir;
    @(posedge core_clk_in) disable iff (!resetn_in)
      fall && state_q == S_SH_IR |=> tdo_out == $past(ir_sh_q[0]);
  endproperty
  a_tdo_ir: assert property (p_tdo_ir) else $error("tdo not showing instruction lsb");

  property p_tdo_bsr;
    @(posedge core_clk_in) disable iff (!resetn_in) s_sh_dr_fall ##0 sel_bsr |=> tdo_out == $past(bsr_q[0]);
  endproperty
  a_tdo_bsr: assert property (p_tdo_bsr) else $error("tdo not showing boundary lsb");

  property p_tdo_byp;
    @(posedge core_clk_in) disable iff (!resetn_in) s_sh_dr_fall ##0 sel_byp |=> tdo_out == $past(byp_q);
  endproperty
  a_tdo_byp: assert property (p_tdo_byp) else $error("tdo not showing bypass bit");

  // the enable must drop on the first fall outside a shift state
  property p_oe_off;
    @(posedge core_clk_in) disable iff (!resetn_in) fall && !shift_st |=> !tdo_oe_out;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("tdo left enabled outside shift");

  property p_byp_shift;
    @(posedge core_clk_in) disable iff (!resetn_in)
      rise && state_q == S_SH_DR && sel_byp |=> byp_q == $past(tdi_s);
  endproperty
  a_byp_shift: assert property (p_byp_shift) else $error("bypass stage did not take tdi");

  property p_bsr_cap;
    @(posedge core_clk_in) disable iff (!resetn_in)
      rise && state_q == S_CAP_DR && sel_bsr |=> bsr_q == $past(pins_in);
  endproperty
  a_bsr_cap: assert property (p_bsr_cap) else $error("pin ring not captured");

  property p_upd_dr;
    @(posedge core_clk_in) disable iff (!resetn_in) rise && state_q == S_UPD_DR |=> $stable(bsr_q);
  endproperty
  a_upd_dr: assert property (p_upd_dr) else $error("update-dr disturbed the boundary register");

  property p_float_off;
    @(posedge core_clk_in) disable iff (!resetn_in) !float_ins |=> !mem_hiz_out;
  endproperty
  a_float_off: assert property (p_float_off) else $error("memory outputs floated without cause");

  property p_one_path;
    @(posedge core_clk_in) disable iff (!resetn_in) $onehot({sel_bsr, sel_id, sel_byp});
  endproperty
  a_one_path: assert property (p_one_path) else $error("scan path selection not unique");
endmodule

/* File: tb/jtag_ctrl_model.sv */
// behavioural boundary-scan controller driving the test clock, mode select and serial input
`timescale 1ns/1ps
module jtag_ctrl_model (
  input  wire logic clk_in,
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  // one test clock period of 20 core cycles; tck rests low between calls
  task automatic step(input logic tms, input logic tdi);
    tms_out = tms;
    tdi_out = tdi;
    repeat (10) @(negedge clk_in);
    tck_out = 1'b1;
    repeat (10) @(negedge clk_in);
    tck_out = 1'b0;
  endtask
  task automatic tap_reset();
    repeat (5) step(1'b1, 1'b1);
  endtask
endmodule

/* File: tb/tb_sram_jtag_test_access_port.sv */
// self-checking bench for the memory test access port
`timescale 1ns/1ps
module tb_sram_jtag_test_access_port;
  import tap_pkg::*;
  localparam int BW = BSR_W_X18;
  logic          core_clk_in = 1'b0;
  logic          resetn_in = 1'b0;
  logic          tms_driven_in = 1'b1;
  logic [BW-1:0] pins_in = '0;
  logic          tck;
  logic          tms;
  logic          tdi;
  logic          tdo_out;
  logic          tdo_oe_out;
  logic          mem_hiz_out;
  logic [2:0]    ir_out;
  logic [2:0]    cur_ir = INS_IDCODE;
  logic          exp_q[$];
  int            num_errors = 0;
  int            tests_run = 0;
  int            cycles = 0;

  initial forever #4 core_clk_in = ~core_clk_in;

  jtag_ctrl_model ctl (.clk_in(core_clk_in), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));

  mem_tap #(.BSR_W(BW)) dut (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .tck_in(tck), .tms_in(tms),
    .tms_driven_in(tms_driven_in), .tdi_in(tdi), .pins_in(pins_in), .tdo_out(tdo_out),
    .tdo_oe_out(tdo_oe_out), .mem_hiz_out(mem_hiz_out), .ir_out(ir_out));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // scan helpers, starting and ending in Run-Test/Idle
  // --------------------------------------------------------------------
  task automatic scan(input logic is_ir, input int n, input logic [127:0] din, input logic [127:0] dexp);
    for (int i = 0; i < n; i++) exp_q.push_back(dexp[i]);
    ctl.step(1'b1, 1'b1);
    if (is_ir) ctl.step(1'b1, 1'b1);
    ctl.step(1'b0, 1'b1);
    ctl.step(1'b0, 1'b1);
    for (int i = 0; i < n; i++) ctl.step(i == n - 1, din[i]);
    ctl.step(1'b1, 1'b1);
    ctl.step(1'b0, 1'b1);
  endtask

  task automatic load_ir(input logic [2:0] code);
    scan(1'b1, 3, 128'(code), 128'({cur_ir[2], 2'b01}));
    cur_ir = code;
    check(ir_out, code, "instruction");
  endtask

  // --------------------------------------------------------------------
  // serial output monitor: every bit shifted out is matched to its note
  // --------------------------------------------------------------------
  always @(posedge tck) begin
    if (tdo_oe_out === 1'b1) begin
      if (exp_q.size() == 0) check(1, 0, "unexpected shift bit");
      else check(tdo_out, exp_q.pop_front(), "serial out");
    end
  end

  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    logic [127:0] d;
    void'($urandom(23353));
    repeat (4) @(negedge core_clk_in);
    resetn_in = 1'b1;
    repeat (8) @(negedge core_clk_in);
    check(tdo_oe_out, 0, "oe after reset");
    check(ir_out, INS_IDCODE, "ir after reset");
    check(mem_hiz_out, 0, "hiz after reset");
    ctl.step(1'b0, 1'b1);
    d = {$urandom, $urandom, $urandom, $urandom};
    // eight extra bits prove the register length: tdi must emerge right after the code
    scan(1'b0, ID_W + 8, d, {d[95:0], ID_VALUE});
    for (int c = 0; c < 8; c++) begin
      load_ir(c[2:0]);
      check(mem_hiz_out, c < 2, "memory float");
      pins_in = BW'({$urandom, $urandom});
      d = {$urandom, $urandom, $urandom, $urandom};
      case (c)
        0, 1, 3: scan(1'b0, BW + 8, d, {d[127-BW:0], pins_in});
        2: scan(1'b0, ID_W + 8, d, {d[95:0], ID_VALUE});
        default: scan(1'b0, 8, d, {d[126:0], 1'b0});
      endcase
      check(tdo_oe_out, 0, "oe in idle");
    end
    // five high mode-select edges from Pause-DR
    load_ir(INS_SAMPLE);
    ctl.step(1'b1, 1'b1);
    ctl.step(1'b0, 1'b1);
    ctl.step(1'b1, 1'b1);
    ctl.step(1'b0, 1'b1);
    ctl.tap_reset();
    cur_ir = INS_IDCODE;
    check(ir_out, INS_IDCODE, "tms reset");
    ctl.step(1'b0, 1'b1);
    // an open mode-select pin must read high and reset the port
    load_ir(INS_BYPASS);
    tms_driven_in = 1'b0;
    repeat (5) ctl.step(1'b0, 1'b1);
    tms_driven_in = 1'b1;
    cur_ir = INS_IDCODE;
    check(ir_out, INS_IDCODE, "open tms reset");
    check(exp_q.size(), 0, "bits left unshifted");
    close_out();
  end
endmodule
